/* File: rtl/fpx_decode.sv */
`default_nettype none
module fpx_decode (
  input wire logic [31:0] instr,
  output fpx_pkg::fpx_dec_t dec
);
  wire [5:0] opc = instr[31:26];
  wire [10:0] fn = instr[15:5];
  wire [5:0] op = fn[5:0];
  wire [1:0] cls_bits = fn[fpx_pkg::FN_SW:fpx_pkg::FN_INE];
  wire is_ieee = opc == fpx_pkg::OPC_IEEE;
  wire is_leg = opc == fpx_pkg::OPC_LEG;
  wire is_quad_to_long_convert = opc == fpx_pkg::OPC_FCPY &&
    (fn == fpx_pkg::FN_QUAD_TO_LONG_CONVERT || fn == fpx_pkg::FN_QUAD_TO_LONG_CONVERT_V || fn == fpx_pkg::FN_QUAD_TO_LONG_CONVERT_SV);
  wire arith_op = op <= fpx_pkg::OP_DIVS ||
    (op >= fpx_pkg::OP_ADDT && op <= fpx_pkg::OP_DIVT);
  wire cmp_op = op >= fpx_pkg::OP_CMPUN && op <= fpx_pkg::OP_CMPLE;
  wire cvq_op = op == fpx_pkg::OP_QUAD_TO_SINGLE_CONVERT || op == fpx_pkg::OP_QUAD_TO_DOUBLE_CONVERT;
  // ieee legality: compares only at normal rounding with fixed classes, quad converts only at fixed class pairs
  wire ieee_round_ok = arith_op || op == fpx_pkg::OP_CVTTS || op == fpx_pkg::OP_T_TO_QUAD_CONVERT;
  wire ieee_cls_ok = cls_bits != 2'h1; // 2xx/3xx codes do not exist
  // /SU taken as /S: compares cannot underflow
  wire ieee_cmp_ok = cmp_op &&
    fn[fpx_pkg::FN_RND_HI:fpx_pkg::FN_RND_LO] == fpx_pkg::RND_NORM &&
    ((cls_bits == 2'h0 && !fn[fpx_pkg::FN_UV]) || cls_bits == 2'h2);
  // quad to ieee: only none or software-underflow-inexact forms
  wire ieee_cvq_ok = cvq_op && ((cls_bits == 2'h0 && !fn[fpx_pkg::FN_UV]) ||
    (cls_bits == 2'h3 && fn[fpx_pkg::FN_UV]));
  wire ieee_cvst = fn == fpx_pkg::FN_CVTST || fn == fpx_pkg::FN_CVTST_S;
  wire ieee_ok = is_ieee && (ieee_cvst || fn == fpx_pkg::FN_QUAD_TO_DOUBLE_CONVERT_SUID || ieee_cmp_ok ||
    ieee_cvq_ok || (ieee_round_ok && ieee_cls_ok));
  // legacy: rounding only none or chopped; no inexact class
  wire leg_rnd_ok = fn[fpx_pkg::FN_RND_LO] == 1'b0;
  wire leg_op_ok = arith_op || op == fpx_pkg::OP_CVTTS || op == fpx_pkg::OP_CVTGD ||
    op == fpx_pkg::OP_T_TO_QUAD_CONVERT || op == fpx_pkg::OP_CVTDG || cmp_op || cvq_op;
  wire leg_ok = is_leg && leg_rnd_ok && !fn[fpx_pkg::FN_INE] && leg_op_ok;
  wire [25:0] palfn = instr[25:0];
  wire is_pal = opc == fpx_pkg::OPC_PAL;
  wire pal_known = palfn == fpx_pkg::PAL_HALT || palfn == fpx_pkg::PAL_DRAIN ||
    palfn == fpx_pkg::PAL_IMB;
  wire fpx_pkg::fpx_pal_t pal = !is_pal ? fpx_pkg::FPX_PAL_NONE :
    palfn == fpx_pkg::PAL_HALT ? fpx_pkg::FPX_PAL_HALT :
    palfn == fpx_pkg::PAL_DRAIN ? fpx_pkg::FPX_PAL_DRAIN :
    palfn == fpx_pkg::PAL_IMB ? fpx_pkg::FPX_PAL_IMB : fpx_pkg::FPX_PAL_NONE;
  wire fpx_pkg::fpx_class_t cls = ieee_ok ? fpx_pkg::FPX_CL_IEEE :
    leg_ok ? fpx_pkg::FPX_CL_LEG :
    is_quad_to_long_convert ? fpx_pkg::FPX_CL_LEG :
    (is_pal && pal_known) ? fpx_pkg::FPX_CL_PAL :
    opc == fpx_pkg::OPC_INTS ? fpx_pkg::FPX_CL_SHIFT :
    opc == fpx_pkg::OPC_JUMP ? fpx_pkg::FPX_CL_JUMP :
    opc == fpx_pkg::OPC_FCPY ? fpx_pkg::FPX_CL_NOEXC : fpx_pkg::FPX_CL_NONE;
  wire fp_any = ieee_ok || leg_ok || is_quad_to_long_convert;
  assign dec.cls = cls;
  assign dec.pal = pal;
  assign dec.legal = cls != fpx_pkg::FPX_CL_NONE;
  assign dec.op = op;
  assign dec.rnd = fn[fpx_pkg::FN_RND_HI:fpx_pkg::FN_RND_LO];
  // /U and /V share bit 8; an inexact-enable code also enables underflow
  assign dec.unf_en = fp_any && (fn[fpx_pkg::FN_UV] || (is_ieee && fn[fpx_pkg::FN_INE]));
  assign dec.iov_en = fp_any && fn[fpx_pkg::FN_UV];
  assign dec.ine_en = (ieee_ok || leg_ok) && fn[fpx_pkg::FN_INE] && fn[fpx_pkg::FN_SW];
  assign dec.sw = fp_any && fn[fpx_pkg::FN_SW];
  assign dec.is_div = fp_any && (op == fpx_pkg::OP_DIVS || op == fpx_pkg::OP_DIVT);
  assign dec.is_cmp = fp_any && cmp_op;
  assign dec.to_int = (ieee_ok || leg_ok) && op == fpx_pkg::OP_T_TO_QUAD_CONVERT;
  assign dec.to_long = is_quad_to_long_convert;
endmodule : fpx_decode
`default_nettype wire

/* File: rtl/fpx_pkg.sv */
`default_nettype none
package fpx_pkg;
  // major opcodes
  localparam logic [5:0] OPC_PAL = 6'h00;
  localparam logic [5:0] OPC_INTS = 6'h12;
  localparam logic [5:0] OPC_JUMP = 6'h1a;
  localparam logic [5:0] OPC_LEG = 6'h15;
  localparam logic [5:0] OPC_IEEE = 6'h16;
  localparam logic [5:0] OPC_FCPY = 6'h17;
  // privileged function codes
  localparam logic [25:0] PAL_HALT = 26'h0000000;
  localparam logic [25:0] PAL_DRAIN = 26'h0000002;
  localparam logic [25:0] PAL_IMB = 26'h0000086;
  // function field layout: [10:9] trap class, [8] underflow/overflow, [7:6] round, [5:0] op
  localparam int FN_SW = 10;
  localparam int FN_INE = 9;
  localparam int FN_UV = 8;
  localparam int FN_RND_HI = 7;
  localparam int FN_RND_LO = 6;
  localparam logic [1:0] RND_CHOP = 2'h0;
  localparam logic [1:0] RND_MINF = 2'h1;
  localparam logic [1:0] RND_NORM = 2'h2;
  localparam logic [1:0] RND_DYN = 2'h3;
  // ieee op codes (low six bits)
  localparam logic [5:0] OP_ADD_SINGLE_IEEE = 6'h00;
  localparam logic [5:0] OP_SUBS = 6'h01;
  localparam logic [5:0] OP_MULS = 6'h02;
  localparam logic [5:0] OP_DIVS = 6'h03;
  localparam logic [5:0] OP_ADDT = 6'h20;
  localparam logic [5:0] OP_SUBT = 6'h21;
  localparam logic [5:0] OP_MULT = 6'h22;
  localparam logic [5:0] OP_DIVT = 6'h23;
  localparam logic [5:0] OP_CMPUN = 6'h24;
  localparam logic [5:0] OP_CMPLE = 6'h27;
  localparam logic [5:0] OP_CVTTS = 6'h2c;
  localparam logic [5:0] OP_CVTGD = 6'h2d;
  localparam logic [5:0] OP_T_TO_QUAD_CONVERT = 6'h2f;
  localparam logic [5:0] OP_QUAD_TO_SINGLE_CONVERT = 6'h3c;
  localparam logic [5:0] OP_QUAD_TO_DOUBLE_CONVERT = 6'h3e;
  localparam logic [5:0] OP_CVTDG = 6'h1e;
  localparam logic [10:0] FN_CVTST = 11'h2ac;
  localparam logic [10:0] FN_CVTST_S = 11'h6ac;
  localparam logic [10:0] FN_QUAD_TO_DOUBLE_CONVERT_SUID = 11'h7f3;
  localparam logic [10:0] FN_QUAD_TO_LONG_CONVERT = 11'h030;
  localparam logic [10:0] FN_QUAD_TO_LONG_CONVERT_V = 11'h130;
  localparam logic [10:0] FN_QUAD_TO_LONG_CONVERT_SV = 11'h530;
  // cause vector bit positions
  localparam int EX_INV = 0;
  localparam int EX_DZE = 1;
  localparam int EX_OVF = 2;
  localparam int EX_UNF = 3;
  localparam int EX_INE = 4;
  localparam int EX_IOV = 5;
  localparam int EX_N = 6;
  localparam logic [EX_N-1:0] EX_NONE = 6'h00;
  localparam logic [EX_N-1:0] EX_INPUT_MASK = 6'h03;
  localparam logic [63:0] TRUE_ZERO = 64'h0000000000000000;

  typedef enum logic [2:0] {
    FPX_CL_NONE = 3'b000,
    FPX_CL_IEEE = 3'b001,
    FPX_CL_LEG = 3'b010,
    FPX_CL_PAL = 3'b011,
    FPX_CL_SHIFT = 3'b100,
    FPX_CL_JUMP = 3'b101,
    FPX_CL_NOEXC = 3'b110
  } fpx_class_t;

  typedef enum logic [1:0] {
    FPX_PAL_NONE = 2'b00,
    FPX_PAL_HALT = 2'b01,
    FPX_PAL_DRAIN = 2'b10,
    FPX_PAL_IMB = 2'b11
  } fpx_pal_t;

  typedef struct packed {
    fpx_class_t cls;
    fpx_pal_t pal;
    logic legal;
    logic [5:0] op;
    logic [1:0] rnd;
    logic unf_en;
    logic iov_en;
    logic ine_en;
    logic sw;
    logic is_div;
    logic is_cmp;
    logic to_int;
    logic to_long;
  } fpx_dec_t;

  // status from the arithmetic datapath at completion
  typedef struct packed {
    logic done;
    logic [31:0] instr;
    logic opnd_bad;
    logic num_zero;
    logic num_valid;
    logic div_zero;
    logic too_big;
    logic too_small;
    logic inexact;
    logic int_out_range;
    logic [63:0] result;
  } fpx_stat_t;

  typedef struct packed {
    logic valid;
    logic [EX_N-1:0] cause;
    logic sw;
  } fpx_trap_t;
endpackage : fpx_pkg
`default_nettype wire

/* File: rtl/fpx_trap_unit.sv */
// What this block does
// - opcode 16 is ieee operate, 11-bit function
// - opcode 15 is legacy operate, same field
// - ieee add rounding qualifier codes decoded
// - software and inexact completion variants decoded
// - t-to-quad conversion variants decoded
// - compare software-underflow equals software-only
// - quad-to-ieee uses software-underflow-inexact forms
// - legacy add qualifier codes decoded
// - halt, drain aborts, barrier under opcode 00
// - shifts opcode 12, jumps opcode 1a
// - bad operand always traps, ieee zero/zero included
// - nonfinite operand traps only excepting ops
// - zero divisor always traps, valid numerator
// - float overflow always traps, float destinations
// - underflow writes true zero, flag always
// - imprecise sets flag, traps when enabled
// - inexact enabled accompanies overflow and underflow
// - quad-to-long integer overflow sets imprecise flag
// - integer overflow keeps low bits, flag
// - integer range limits 64 and 32 bit
// - completion state to issue unit, not stored
// - input exceptions suppress output exceptions
`default_nettype none
module fpx_trap_unit (
  input wire logic clk,
  input wire logic rst,
  input wire fpx_pkg::fpx_stat_t stat,
  input wire logic clear_flags,
  output fpx_pkg::fpx_trap_t trap_r,
  output logic [fpx_pkg::EX_N-1:0] fp_control_register_r,
  output logic [63:0] result_r,
  output logic result_valid_r,
  output fpx_pkg::fpx_class_t class_r,
  output fpx_pkg::fpx_pal_t pal_r,
  output logic illegal_r
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  fpx_pkg::fpx_dec_t dec;

  fpx_decode u_dec (
    .instr(stat.instr),
    .dec(dec)
  );

  // ------------------------------------------------------------
  // exception detection
  // ------------------------------------------------------------
  wire fp_op = stat.done && (dec.cls == fpx_pkg::FPX_CL_IEEE || dec.cls == fpx_pkg::FPX_CL_LEG);
  wire is_ieee = dec.cls == fpx_pkg::FPX_CL_IEEE;
  // copy-sign group never excepts
  wire bad_opnd = fp_op && stat.opnd_bad;
  // ieee 0/0 is bad operand, not zero divisor
  wire zero_by_zero = fp_op && is_ieee && dec.is_div && stat.div_zero &&
    stat.num_zero && stat.num_valid;
  wire ex_inv = bad_opnd || zero_by_zero;
  wire dze_ok_num = is_ieee ? (stat.num_valid && !stat.num_zero) : stat.num_valid;
  wire ex_dze = fp_op && dec.is_div && stat.div_zero && dze_ok_num;
  wire fp_dest = !dec.to_int && !dec.to_long && !dec.is_cmp;
  wire ex_ovf = fp_op && fp_dest && stat.too_big;
  wire ex_unf = fp_op && fp_dest && stat.too_small;
  // range test done by datapath: 64-bit for float-to-int, 32-bit for quad-to-long
  wire ex_iov = fp_op && (dec.to_int || dec.to_long) && stat.int_out_range;
  wire ex_ine = fp_op && (stat.inexact || (dec.to_long && ex_iov));

  wire [fpx_pkg::EX_N-1:0] raw;
  assign raw[fpx_pkg::EX_INV] = ex_inv;
  assign raw[fpx_pkg::EX_DZE] = ex_dze;
  assign raw[fpx_pkg::EX_OVF] = ex_ovf;
  assign raw[fpx_pkg::EX_UNF] = ex_unf;
  assign raw[fpx_pkg::EX_INE] = ex_ine;
  assign raw[fpx_pkg::EX_IOV] = ex_iov;

  // an input exception hides all output exceptions
  wire has_input = |(raw & fpx_pkg::EX_INPUT_MASK);
  wire [fpx_pkg::EX_N-1:0] recorded = has_input ? (raw & fpx_pkg::EX_INPUT_MASK) : raw;

  // trap enables: input and overflow always on
  wire [fpx_pkg::EX_N-1:0] enable;
  assign enable[fpx_pkg::EX_INV] = 1'b1;
  assign enable[fpx_pkg::EX_DZE] = 1'b1;
  assign enable[fpx_pkg::EX_OVF] = 1'b1;
  assign enable[fpx_pkg::EX_UNF] = dec.unf_en;
  assign enable[fpx_pkg::EX_INE] = dec.ine_en;
  assign enable[fpx_pkg::EX_IOV] = dec.iov_en;

  // with inexact enabled, overflow/underflow drag inexact along
  wire [fpx_pkg::EX_N-1:0] signaled_base = recorded & enable;
  wire ine_drag = dec.ine_en && (signaled_base[fpx_pkg::EX_OVF] || signaled_base[fpx_pkg::EX_UNF]);
  wire [fpx_pkg::EX_N-1:0] signaled = ine_drag && !has_input ?
    (signaled_base | (fpx_pkg::EX_N'(1) << fpx_pkg::EX_INE)) : signaled_base;
  wire [fpx_pkg::EX_N-1:0] flags_set = ine_drag && !has_input ?
    (recorded | (fpx_pkg::EX_N'(1) << fpx_pkg::EX_INE)) : recorded;

  // ------------------------------------------------------------
  // result forcing
  // ------------------------------------------------------------
  // underflow forces +0 even where -0 would be correct; no denormals
  wire [63:0] res_nxt = (ex_unf && !has_input) ? fpx_pkg::TRUE_ZERO : stat.result;
  // integer overflow keeps the low-order bits the datapath produced

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  fpx_pkg::fpx_trap_t trap_nxt;
  assign trap_nxt.valid = stat.done && (|signaled);
  assign trap_nxt.cause = stat.done ? signaled : fpx_pkg::EX_NONE;
  // completion state is forwarded each completion, never stored in the flags
  assign trap_nxt.sw = stat.done && dec.sw;

  // set beats clear so a coincident exception is kept
  wire [fpx_pkg::EX_N-1:0] fcr_nxt =
    (clear_flags ? fpx_pkg::EX_NONE : fp_control_register_r) | flags_set;

  always_ff @(posedge clk) begin
    if (rst) begin
      trap_r <= '0;
      fp_control_register_r <= fpx_pkg::EX_NONE;
      result_r <= fpx_pkg::TRUE_ZERO;
      result_valid_r <= 1'b0;
      class_r <= fpx_pkg::FPX_CL_NONE;
      pal_r <= fpx_pkg::FPX_PAL_NONE;
      illegal_r <= 1'b0;
    end else begin
      trap_r <= trap_nxt;
      fp_control_register_r <= fcr_nxt;
      result_r <= res_nxt;
      result_valid_r <= stat.done;
      class_r <= stat.done ? dec.cls : fpx_pkg::FPX_CL_NONE;
      pal_r <= stat.done ? dec.pal : fpx_pkg::FPX_PAL_NONE;
      illegal_r <= stat.done && !dec.legal;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_inv_always: assert property (@(posedge clk) disable iff (rst)
    stat.done && ex_inv |=> trap_r.valid && trap_r.cause[fpx_pkg::EX_INV]
      && fp_control_register_r[fpx_pkg::EX_INV])
    else $error("bad operand not trapped");
  a_dze_always: assert property (@(posedge clk) disable iff (rst)
    ex_dze && !zero_by_zero |=> trap_r.cause[fpx_pkg::EX_DZE])
    else $error("zero divisor not trapped");
  a_zero_zero: assert property (@(posedge clk) disable iff (rst)
    zero_by_zero |=> !trap_r.cause[fpx_pkg::EX_DZE])
    else $error("zero over zero gave zero divisor");
  a_input_priority: assert property (@(posedge clk) disable iff (rst)
    stat.done && has_input |=> (trap_r.cause & ~fpx_pkg::EX_INPUT_MASK) == fpx_pkg::EX_NONE)
    else $error("output exception beside input exception");
  a_unf_zero: assert property (@(posedge clk) disable iff (rst)
    ex_unf && !has_input |=> result_r == fpx_pkg::TRUE_ZERO
      && fp_control_register_r[fpx_pkg::EX_UNF])
    else $error("underflow result not zero");
  a_unf_gate: assert property (@(posedge clk) disable iff (rst)
    stat.done && !dec.unf_en |=> !trap_r.cause[fpx_pkg::EX_UNF])
    else $error("underflow trapped while disabled");
  a_ine_follows: assert property (@(posedge clk) disable iff (rst)
    trap_r.cause[fpx_pkg::EX_OVF] && $past(dec.ine_en) |-> trap_r.cause[fpx_pkg::EX_INE])
    else $error("overflow without inexact");
  a_quad_to_long_convert_ine: assert property (@(posedge clk) disable iff (rst)
    stat.done && dec.to_long && ex_iov && !has_input
      |=> fp_control_register_r[fpx_pkg::EX_INE] && !trap_r.cause[fpx_pkg::EX_INE])
    else $error("quad to long overflow flag wrong");
  a_iov_gate: assert property (@(posedge clk) disable iff (rst)
    stat.done && !dec.iov_en |=> !trap_r.cause[fpx_pkg::EX_IOV])
    else $error("integer overflow trapped while disabled");
  a_sw_forward: assert property (@(posedge clk) disable iff (rst)
    stat.done |=> trap_r.sw == $past(dec.sw))
    else $error("completion state not forwarded");
  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    fp_control_register_r[fpx_pkg::EX_INE] && !clear_flags |=> fp_control_register_r[fpx_pkg::EX_INE])
    else $error("flag lost");
  a_ieee_decode: assert property (@(posedge clk) disable iff (rst)
    stat.done && stat.instr[31:26] == fpx_pkg::OPC_IEEE && stat.instr[15:5] == 11'h180
      |-> dec.cls == fpx_pkg::FPX_CL_IEEE && dec.unf_en && !dec.sw)
    else $error("underflow add code misdecoded");
endmodule : fpx_trap_unit
`default_nettype wire

/* File: verif/fpx_issue_model.sv */
`default_nettype none
// ----------------------------------------
// issue unit stand-in
// ----------------------------------------
module fpx_issue_model (
  input wire logic clk,
  input wire logic rst,
  input wire fpx_pkg::fpx_trap_t trap,
  output logic sw_summary_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sw_summary_nxt;
  // sampled in the completion cycle only, nothing is queued
  assign sw_summary_nxt = sw_summary_r | (trap.valid & trap.sw);
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_summary_r <= 1'b0;
    end else begin
      sw_summary_r <= sw_summary_nxt;
    end
  end
endmodule : fpx_issue_model
`default_nettype wire

/* File: verif/test_fp_function_decode_and_traps.sv */
`default_nettype none
module test_fp_function_decode_and_traps;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus codes
  // ----------------------------------------
  localparam logic [7:0] B_BAD = 8'h80;
  localparam logic [7:0] B_NZ = 8'h40;
  localparam logic [7:0] B_NV = 8'h20;
  localparam logic [7:0] B_DZ = 8'h10;
  localparam logic [7:0] B_BIG = 8'h08;
  localparam logic [7:0] B_SMALL = 8'h04;
  localparam logic [7:0] B_INE = 8'h02;
  localparam logic [7:0] B_IOR = 8'h01;
  localparam logic [10:0] IEEE_FN [18] = '{11'h080, 11'h000, 11'h040, 11'h0c0, 11'h180,
    11'h580, 11'h500, 11'h540, 11'h5c0, 11'h780, 11'h7c0, 11'h0af, 11'h02f, 11'h1af,
    11'h12f, 11'h5af, 11'h5a5, 11'h7bc};
  localparam logic [10:0] LEG_FN [8] = '{11'h080, 11'h000, 11'h180, 11'h100, 11'h480,
    11'h400, 11'h580, 11'h500};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clear_flags = 1'b0;
  fpx_pkg::fpx_stat_t stat = '0;
  fpx_pkg::fpx_trap_t trap_r;
  logic [fpx_pkg::EX_N-1:0] fcr;
  logic [63:0] result_r;
  logic result_valid_r;
  logic illegal_r;
  logic sw_summary;
  fpx_pkg::fpx_class_t class_r;
  fpx_pkg::fpx_pal_t pal_r;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  fpx_trap_unit uut (.clk(clk), .rst(rst), .stat(stat), .clear_flags(clear_flags),
    .trap_r(trap_r), .fp_control_register_r(fcr), .result_r(result_r),
    .result_valid_r(result_valid_r), .class_r(class_r), .pal_r(pal_r), .illegal_r(illegal_r));
  fpx_issue_model issue (.clk(clk), .rst(rst), .trap(trap_r), .sw_summary_r(sw_summary));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  function automatic logic [31:0] ins(input logic [5:0] opc, input logic [10:0] fn);
    return {opc, 10'h000, fn, 5'h00};
  endfunction : ins
  task automatic fail(input string msg);
    bad_count++;
    $display("Error %0t %s", $time, msg);
  endtask : fail
  // entered at a falling edge; outputs are looked at one cycle later
  task automatic xact(input logic [31:0] i, input logic [7:0] ev, input logic [63:0] res);
    stat = {1'b1, i, ev, res};
    @(negedge clk);
  endtask : xact
  task automatic clr();
    stat.done = 1'b0;
    clear_flags = 1'b1;
    @(negedge clk);
    clear_flags = 1'b0;
  endtask : clr
  task automatic chk_trap(input logic v, input logic [5:0] c, input logic s);
    comparisons++;
    if (trap_r !== {v, c, s}) fail("trap output wrong");
  endtask : chk_trap
  task automatic chk_flags(input logic [5:0] f);
    comparisons++;
    if (fcr !== f) fail("sticky flags wrong");
  endtask : chk_flags
  task automatic chk_res(input logic [63:0] r);
    comparisons++;
    if (result_r !== r || result_valid_r !== 1'b1) fail("result wrong");
  endtask : chk_res
  task automatic chk_dec(input fpx_pkg::fpx_class_t c, input fpx_pkg::fpx_pal_t p,
                         input logic ill);
    comparisons++;
    if (class_r !== c || pal_r !== p || illegal_r !== ill) fail("decode wrong");
  endtask : chk_dec
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) fail("flag bit wrong");
  endtask : chk_bit
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk_flags(6'h00);
    chk_bit(sw_summary, 1'b0);
    xact(ins(fpx_pkg::OPC_IEEE, 11'h583), B_DZ | B_NV, 64'h0);
    chk_trap(1'b1, 6'h02, 1'b1);
    chk_flags(6'h02);
    clr();
    chk_bit(sw_summary, 1'b1);
    chk_flags(6'h00);
    xact(ins(fpx_pkg::OPC_IEEE, 11'h083), B_NZ | B_NV | B_DZ, 64'h0);
    chk_trap(1'b1, 6'h01, 1'b0);
    xact(ins(fpx_pkg::OPC_LEG, 11'h083), B_NZ | B_NV | B_DZ, 64'h0);
    chk_trap(1'b1, 6'h02, 1'b0);
    chk_flags(6'h03);
    clr();
    xact(ins(fpx_pkg::OPC_IEEE, 11'h0a0), B_BIG, 64'h0);
    chk_trap(1'b1, 6'h04, 1'b0);
    chk_flags(6'h04);
    clr();
    // underflow not enabled: flagged but silent, and the sign is dropped
    xact(ins(fpx_pkg::OPC_IEEE, 11'h080), B_SMALL | B_INE, 64'h8000000000000000);
    chk_trap(1'b0, 6'h00, 1'b0);
    chk_res(64'h0000000000000000);
    chk_flags(6'h18);
    xact(ins(fpx_pkg::OPC_IEEE, 11'h180), B_SMALL, 64'h0000000000000001);
    chk_trap(1'b1, 6'h08, 1'b0);
    xact(ins(fpx_pkg::OPC_IEEE, 11'h780), B_SMALL, 64'h0);
    chk_trap(1'b1, 6'h18, 1'b1);
    xact(ins(fpx_pkg::OPC_IEEE, 11'h7c0), B_INE, 64'h3f80000012345678);
    chk_trap(1'b1, 6'h10, 1'b1);
    chk_res(64'h3f80000012345678);
    xact(ins(fpx_pkg::OPC_IEEE, 11'h7a0), B_BIG, 64'h0);
    chk_trap(1'b1, 6'h14, 1'b1);
    xact(ins(fpx_pkg::OPC_IEEE, 11'h7bc), B_INE, 64'h0);
    chk_trap(1'b1, 6'h10, 1'b1);
    clr();
    xact(ins(fpx_pkg::OPC_IEEE, 11'h080), B_BAD | B_BIG | B_INE, 64'h0);
    chk_trap(1'b1, 6'h01, 1'b0);
    chk_flags(6'h01);
    clr();
    xact(ins(fpx_pkg::OPC_FCPY, 11'h020), B_BAD, 64'h0);
    chk_trap(1'b0, 6'h00, 1'b0);
    chk_dec(fpx_pkg::FPX_CL_NOEXC, fpx_pkg::FPX_PAL_NONE, 1'b0);
    chk_flags(6'h00);
    xact(ins(fpx_pkg::OPC_FCPY, 11'h130), B_IOR, 64'hffffffff80000000);
    chk_trap(1'b1, 6'h20, 1'b0);
    chk_res(64'hffffffff80000000);
    chk_flags(6'h30);
    xact(ins(fpx_pkg::OPC_FCPY, 11'h030), B_IOR, 64'h0);
    chk_trap(1'b0, 6'h00, 1'b0);
    xact(ins(fpx_pkg::OPC_FCPY, 11'h530), B_IOR, 64'h0);
    chk_trap(1'b1, 6'h20, 1'b1);
    clr();
    xact(ins(fpx_pkg::OPC_IEEE, 11'h0af), B_IOR, 64'h0);
    chk_trap(1'b0, 6'h00, 1'b0);
    chk_flags(6'h20);
    xact(ins(fpx_pkg::OPC_IEEE, 11'h1af), B_IOR, 64'h0);
    chk_trap(1'b1, 6'h20, 1'b0);
    xact(ins(fpx_pkg::OPC_IEEE, 11'h7af), B_INE, 64'h0);
    chk_trap(1'b1, 6'h10, 1'b1);
    xact(ins(fpx_pkg::OPC_IEEE, 11'h5a5), B_BAD, 64'h0);
    chk_trap(1'b1, 6'h01, 1'b1);
    // decode sweep, completions back to back
    foreach (IEEE_FN[k]) begin
      xact(ins(fpx_pkg::OPC_IEEE, IEEE_FN[k]), 8'h00, 64'h0);
      chk_dec(fpx_pkg::FPX_CL_IEEE, fpx_pkg::FPX_PAL_NONE, 1'b0);
    end
    foreach (LEG_FN[k]) begin
      xact(ins(fpx_pkg::OPC_LEG, LEG_FN[k]), 8'h00, 64'h0);
      chk_dec(fpx_pkg::FPX_CL_LEG, fpx_pkg::FPX_PAL_NONE, 1'b0);
    end
    xact({fpx_pkg::OPC_PAL, fpx_pkg::PAL_HALT}, 8'h00, 64'h0);
    chk_dec(fpx_pkg::FPX_CL_PAL, fpx_pkg::FPX_PAL_HALT, 1'b0);
    xact({fpx_pkg::OPC_PAL, fpx_pkg::PAL_DRAIN}, 8'h00, 64'h0);
    chk_dec(fpx_pkg::FPX_CL_PAL, fpx_pkg::FPX_PAL_DRAIN, 1'b0);
    xact({fpx_pkg::OPC_PAL, fpx_pkg::PAL_IMB}, 8'h00, 64'h0);
    chk_dec(fpx_pkg::FPX_CL_PAL, fpx_pkg::FPX_PAL_IMB, 1'b0);
    xact(ins(fpx_pkg::OPC_INTS, 11'h039), 8'h00, 64'h0);
    chk_dec(fpx_pkg::FPX_CL_SHIFT, fpx_pkg::FPX_PAL_NONE, 1'b0);
    xact(ins(fpx_pkg::OPC_JUMP, 11'h000), 8'h00, 64'h0);
    chk_dec(fpx_pkg::FPX_CL_JUMP, fpx_pkg::FPX_PAL_NONE, 1'b0);
    // out-of-table qualifier combinations
    xact(ins(fpx_pkg::OPC_IEEE, 11'h280), 8'h00, 64'h0);
    chk_bit(illegal_r, 1'b1);
    xact(ins(fpx_pkg::OPC_LEG, 11'h040), 8'h00, 64'h0);
    chk_bit(illegal_r, 1'b1);
    xact(ins(fpx_pkg::OPC_LEG, 11'h780), 8'h00, 64'h0);
    chk_bit(illegal_r, 1'b1);
    clr();
    give_verdict();
  end
endmodule : test_fp_function_decode_and_traps
`default_nettype wire
